// ### hw/mrt_pkg.sv
// Shared constants and types for the mode register three link.
// Assumes both ends run on one common clock at CLK_HZ.
package mrt_pkg;
  localparam int          REG_W     = 22;
  localparam int          SEL_LO    = 18;
  localparam int          RSV_HI    = 21;
  localparam int          RSV_MID   = 17;
  localparam int          RSV_LO    = 13;
  localparam int          FMT_LO    = 11;
  localparam int          WCL_LO    = 9;
  localparam int          FGR_LO    = 6;
  localparam int          TSR_BIT   = 5;
  localparam int          PDA_BIT   = 4;
  localparam int          GEAR_BIT  = 3;
  localparam int          RBS_BIT   = 2;
  localparam int          PAGE_LO   = 0;
  localparam logic [2:0]  SEL_THIS  = 3'h3;
  localparam logic [21:0] MR_RESET  = 22'h000000;
  localparam logic [1:0]  FMT_SERIAL   = 2'h0;
  localparam logic [1:0]  FMT_PARALLEL = 2'h1;
  localparam logic [1:0]  FMT_STAGGER  = 2'h2;
  localparam logic [1:0]  CODE_RSV2    = 2'h3;
  localparam logic [2:0]  FGR_RSV_A    = 3'h3;
  localparam logic [2:0]  FGR_RSV_B    = 3'h4;
  localparam logic [2:0]  FGR_RSV_C    = 3'h7;
  localparam logic [2:0]  WCL_BASE  = 3'h4;
  localparam logic [1:0]  WCL_4CK   = 2'h0;
  localparam logic [1:0]  WCL_5CK   = 2'h1;
  localparam logic [1:0]  WCL_6CK   = 2'h2;
  localparam int          RATE_LOW  = 1600;
  localparam int          RATE_MID  = 2666;
  localparam logic [3:0]  FRAME_PLAIN = 4'h8;
  localparam logic [3:0]  FRAME_CRC   = 4'ha;
  localparam int          BURST_LEN = 8;
  localparam logic [2:0]  CMD_MRS   = 3'h0;
  localparam logic [2:0]  CMD_WR    = 3'h4;
  localparam logic [2:0]  CMD_RD    = 3'h5;
  localparam logic [2:0]  CMD_NOP   = 3'h7;
  localparam int          AUTO_PRE_BIT = 10;
  localparam logic [1:0]  PAGE_PATTERN = 2'h0;
  localparam logic [1:0]  PAGE_ERROR   = 2'h1;
  localparam logic [1:0]  PAGE_STATUS  = 2'h2;
  localparam int          TEMP_LO   = 3;
  localparam logic [7:0]  PATTERN_RESET = 8'h00;
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          TEMP_REFRESH_MS = 32;
  localparam int          TEMP_REFRESH_CYC = CLK_HZ / 1000 * TEMP_REFRESH_MS;

  typedef enum logic [1:0] {
    OP_MODE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } mrt_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_READ = 2'b10
  } mrt_state_t;
endpackage

// ### hw/mrt_link_if.sv
// Command, address and readback lines between controller and memory device.
// Both ends sample these on the same clock edge; no synchronisers are needed.
`timescale 1ns/10ps
interface mrt_link_if;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  bank_group_lines;
  logic [1:0]  bank_lines;
  logic [17:0] address_lines;
  logic [7:0]  wdata;
  logic        sync;
  logic        dev_pick_n;
  logic [7:0]  rdata;
  logic        rvalid;

  modport dev (input cs_n, ras_n, cas_n, we_n, bank_group_lines, bank_lines, address_lines, wdata, sync,
               dev_pick_n, output rdata, rvalid);
  modport ctrl (output cs_n, ras_n, cas_n, we_n, bank_group_lines, bank_lines, address_lines, wdata, sync,
                dev_pick_n, input rdata, rvalid);
endinterface

// ### hw/mrt_tick.sv
// Divider that gives a one-cycle enable pulse every PERIOD cycles.
// Assumes PERIOD is at least 2.
`timescale 1ns/10ps
module mrt_tick #(
  parameter int PERIOD = mrt_pkg::TEMP_REFRESH_CYC
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  output logic      tick_out
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] count;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count == LAST);
      count    <= (count == LAST) ? '0 : count + 1'b1;
    end
  end
endmodule

// ### hw/mrt_device.sv
// Device end: mode register three and its readback store.
// Assumes the controller drives the link on clk_in; temp_in comes from an unrelated sensor clock.
//
// Behaviour
// R1: Controller holds ras, cas, we low on mode-set.
// R2: Bank lines carry bits 21:18; select 011 targets.
// R3: Controller writes reserved bits 21, 17, 13 zero.
// R4: Bits 12:11 pick serial, parallel, staggered readback.
// R5: Bits 10:9 give four, five or six clocks.
// R6: Latency applies when CRC and mask both on.
// R7: Controller picks latency code from data rate.
// R8: Bits 8:6 pick fixed or on-the-fly refresh granularity.
// R9: Bit 5 keeps temperature in page 2 location 0.
// R10: Temperature status refreshed at least every 32 ms.
// R11: Bit 4 makes mode-sets per-device selectable.
// R12: Bit 3 selects half or quarter rate clocking.
// R13: Quarter rate needs mode-set then sync pulse.
// R14: Half rate needs no mode-set or sync.
// R15: Bit 2 set enters readback-store access mode.
// R16: Bits 1:0 select page; page 3 unreliable.
// R17: Controller enables readback only with banks idle.
// R18: Reads in readback mode go to store locations.
// R19: Mode register returned as two halves.
// R20: Only reads and writes allowed in readback mode; the code also accepts mode-sets there.
// R21: Reset in readback mode forces full re-initialisation.
// R22: Store holds register, pattern and error-frame pages.
// R23: Fields hold until next targeted mode-set.
// R24: CRC writes use ten-interval frames instead of eight.
`timescale 1ns/10ps
module mrt_device #(
  parameter int TEMP_CYC = mrt_pkg::TEMP_REFRESH_CYC,
  parameter int BURST    = mrt_pkg::BURST_LEN
) (
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  mrt_link_if.dev     link,
  input  wire logic [1:0] temp_in,
  input  wire logic   crc_en_in,
  input  wire logic   mask_en_in,
  input  wire logic   parity_err_in,
  output logic [1:0]  read_format_out,
  output logic [2:0]  crc_mask_write_latency_out,
  output logic [3:0]  write_frame_len_out,
  output logic [2:0]  refresh_mode_out,
  output logic        temp_report_out,
  output logic [1:0]  temp_status_out,
  output logic        per_device_out,
  output logic        quarter_rate_out,
  output logic        gear_aligned_out,
  output logic        gear_phase_out,
  output logic        readback_mode_out,
  output logic [1:0]  page_out,
  output logic        reserved_err_out,
  output logic        cmd_err_out
);
  localparam int BW = $clog2(BURST + 1);

  logic [21:0]   mode_register_three;
  logic [21:0]   word;
  logic [2:0]    cmd;
  logic          cmd_live;
  logic          mrs_hit;
  logic          rd_hit;
  logic          wr_hit;
  logic          bad_fields;
  logic [1:0]    temp_s1;
  logic [1:0]    temp_s2;
  logic [1:0]    temp_s3;
  logic [1:0]    temp_stable;
  logic          temp_tick;
  logic [7:0]    pattern [4];
  logic [7:0]    err_frame [4];
  logic [7:0]    burst_byte;
  logic [7:0]    next_byte;
  logic [1:0]    burst_fmt;
  logic [BW-1:0] beat;
  logic          bursting;

  // Register image as the bank and address lines present it; ras, cas, we positions read as zero.
  assign word     = {link.bank_group_lines, link.bank_lines, link.address_lines[17], 3'h0,
                     link.address_lines[13:0]};  // [R2]
  assign cmd      = {link.ras_n, link.cas_n, link.we_n};
  assign cmd_live = !link.cs_n && (cmd != mrt_pkg::CMD_NOP);
  assign mrs_hit  = !link.cs_n && (cmd == mrt_pkg::CMD_MRS)
                    && (word[mrt_pkg::SEL_LO +: 3] == mrt_pkg::SEL_THIS)  // [R1] [R2]
                    && (!mode_register_three[mrt_pkg::PDA_BIT] || !link.dev_pick_n);  // [R11]
  assign rd_hit   = !link.cs_n && (cmd == mrt_pkg::CMD_RD) && mode_register_three[mrt_pkg::RBS_BIT];
  assign wr_hit   = !link.cs_n && (cmd == mrt_pkg::CMD_WR) && mode_register_three[mrt_pkg::RBS_BIT];

  assign bad_fields = word[mrt_pkg::RSV_HI] || word[mrt_pkg::RSV_MID] || word[mrt_pkg::RSV_LO]  // [R3]
                      || (word[mrt_pkg::FMT_LO +: 2] == mrt_pkg::CODE_RSV2)  // [R4]
                      || (word[mrt_pkg::WCL_LO +: 2] == mrt_pkg::CODE_RSV2)  // [R5]
                      || (word[mrt_pkg::FGR_LO +: 3] == mrt_pkg::FGR_RSV_A)  // [R8]
                      || (word[mrt_pkg::FGR_LO +: 3] == mrt_pkg::FGR_RSV_B)
                      || (word[mrt_pkg::FGR_LO +: 3] == mrt_pkg::FGR_RSV_C);

  // Asynchronous reset clears every mode, including readback access, so the
  // controller must initialise the device from scratch afterwards.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_register_three <= mrt_pkg::MR_RESET;  // [R21]
    end else if (mrs_hit) begin
      mode_register_three <= word;  // [R23]
    end
  end

  // Reserved values are stored as written but flagged until the next targeted mode-set.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reserved_err_out <= 1'b0;
    end else if (mrs_hit) begin
      reserved_err_out <= bad_fields;  // [R3]
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_err_out <= 1'b0;
    end else if (mrs_hit) begin
      cmd_err_out <= 1'b0;
    end else if (cmd_live && mode_register_three[mrt_pkg::RBS_BIT] && (cmd != mrt_pkg::CMD_RD)
                 && (cmd != mrt_pkg::CMD_WR) && (cmd != mrt_pkg::CMD_MRS)) begin
      cmd_err_out <= 1'b1;  // [R20]
    end
  end

  assign read_format_out   = mode_register_three[mrt_pkg::FMT_LO +: 2];  // [R4]
  assign refresh_mode_out  = mode_register_three[mrt_pkg::FGR_LO +: 3];  // [R8]
  assign temp_report_out   = mode_register_three[mrt_pkg::TSR_BIT];  // [R9]
  assign per_device_out    = mode_register_three[mrt_pkg::PDA_BIT];  // [R11]
  assign quarter_rate_out  = mode_register_three[mrt_pkg::GEAR_BIT];  // [R12]
  assign readback_mode_out = mode_register_three[mrt_pkg::RBS_BIT];  // [R15]
  assign page_out          = mode_register_three[mrt_pkg::PAGE_LO +: 2];  // [R16]

  // Latency is the base plus the code; zero means no extra latency is in force.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      crc_mask_write_latency_out <= 3'h0;
      write_frame_len_out        <= mrt_pkg::FRAME_PLAIN;
    end else begin
      crc_mask_write_latency_out <= (crc_en_in && mask_en_in)  // [R6]
          ? mrt_pkg::WCL_BASE + {1'b0, mode_register_three[mrt_pkg::WCL_LO +: 2]} : 3'h0;  // [R5]
      write_frame_len_out <= crc_en_in ? mrt_pkg::FRAME_CRC : mrt_pkg::FRAME_PLAIN;  // [R24]
    end
  end

  // Gear-down: alignment waits for the sync pulse after quarter rate is programmed.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gear_aligned_out <= 1'b0;
      gear_phase_out   <= 1'b0;
    end else if (!mode_register_three[mrt_pkg::GEAR_BIT]) begin
      gear_aligned_out <= 1'b0;  // [R14]
      gear_phase_out   <= 1'b0;
    end else if (link.sync) begin
      gear_aligned_out <= 1'b1;  // [R13]
      gear_phase_out   <= 1'b0;
    end else if (gear_aligned_out) begin
      gear_phase_out <= !gear_phase_out;
    end
  end

  // The sensor level is only trusted once the second and third stages agree.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      temp_s1     <= 2'h0;
      temp_s2     <= 2'h0;
      temp_s3     <= 2'h0;
      temp_stable <= 2'h0;
    end else begin
      temp_s1 <= temp_in;
      temp_s2 <= temp_s1;
      temp_s3 <= temp_s2;
      if (temp_s2 == temp_s3) begin
        temp_stable <= temp_s3;
      end
    end
  end

  mrt_tick #(
    .PERIOD (TEMP_CYC)
  ) u_temp_tick (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_out   (temp_tick)
  );

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      temp_status_out <= 2'h0;
    end else if (!mode_register_three[mrt_pkg::TSR_BIT]) begin
      temp_status_out <= 2'h0;
    end else if (temp_tick) begin
      temp_status_out <= temp_stable;  // [R9] [R10]
    end
  end

  // Calibration patterns and the captured parity error frame, one byte per location.
  for (genvar i = 0; i < 4; i++) begin : g_loc
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        pattern[i]   <= mrt_pkg::PATTERN_RESET;
        err_frame[i] <= 8'h00;
      end else begin
        if (wr_hit && (page_out == mrt_pkg::PAGE_PATTERN) && (link.address_lines[1:0] == 2'(i))) begin
          pattern[i] <= link.wdata;  // [R22]
        end
        if (parity_err_in) begin
          err_frame[i] <= 8'(word >> (8 * i));  // [R22]
        end
      end
    end
  end

  // Location chosen by the read's address bits; the register comes out as lower and upper halves.
  always_comb begin
    next_byte = 8'h00;
    unique case (page_out)
      mrt_pkg::PAGE_PATTERN: next_byte = pattern[link.address_lines[1:0]];
      mrt_pkg::PAGE_ERROR:   next_byte = err_frame[link.address_lines[1:0]];
      mrt_pkg::PAGE_STATUS: begin
        unique case (link.address_lines[1:0])
          2'h0: next_byte = {3'h0, temp_status_out, 3'h0};  // [R9]
          2'h1: next_byte = {5'h00, crc_mask_write_latency_out};
          2'h2: next_byte = mode_register_three[7:0];  // [R19]
          2'h3: next_byte = mode_register_three[15:8];  // [R19]
        endcase
      end
      default: next_byte = 8'h00;  // [R16]
    endcase
  end

  function automatic logic [7:0] beat_data(input logic [7:0] b, input logic [1:0] f, input logic [2:0] i);
    logic [15:0] rot;
    rot = {b, b} << i;
    case (f)
      mrt_pkg::FMT_SERIAL:  beat_data = {8{b[3'h7 - i]}};
      mrt_pkg::FMT_STAGGER: beat_data = rot[15:8];
      default:              beat_data = b;
    endcase
  endfunction

  assign bursting = (beat != '0);

  // A read that lands during a running burst is dropped; the controller never overlaps them.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      beat       <= '0;
      burst_byte <= 8'h00;
      burst_fmt  <= mrt_pkg::FMT_SERIAL;
    end else if (rd_hit && !bursting) begin
      beat       <= BW'(BURST);  // [R18]
      burst_byte <= next_byte;
      burst_fmt  <= read_format_out;
    end else if (bursting) begin
      beat <= beat - 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      link.rdata  <= 8'h00;
      link.rvalid <= 1'b0;
    end else begin
      link.rvalid <= bursting;
      link.rdata  <= bursting ? beat_data(burst_byte, burst_fmt, 3'(BURST - int'(beat))) : 8'h00;  // [R4]
    end
  end
endmodule

// ### hw/mrt_ctrl.sv
// Controller end: programs mode register three and runs readback-store reads and writes.
// Assumes the device samples the link on the same clk_in edge.
`timescale 1ns/10ps
module mrt_ctrl #(
  parameter int BURST = mrt_pkg::BURST_LEN
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  mrt_link_if.ctrl          link,
  input  wire logic         req_in,
  input  mrt_pkg::mrt_op_t  op_in,
  input  wire logic [12:0]  mode_in,
  input  wire logic [11:0]  rate_in,
  input  wire logic [1:0]   loc_in,
  input  wire logic         auto_pre_in,
  input  wire logic [7:0]   wdata_in,
  input  wire logic         banks_idle_in,
  input  wire logic         pick_n_in,
  output logic              busy_out,
  output logic              done_out,
  output logic              refused_out,
  output logic [7:0]        rdata_out,
  output logic              rvalid_out
);
  localparam int BW = $clog2(BURST + 1);

  mrt_pkg::mrt_state_t state;
  logic                readback;
  logic [1:0]          wcl_code;
  logic [BW-1:0]       got;
  logic                refuse;

  always_comb begin
    if (rate_in <= 12'(mrt_pkg::RATE_LOW)) begin
      wcl_code = mrt_pkg::WCL_4CK;  // [R7]
    end else if (rate_in <= 12'(mrt_pkg::RATE_MID)) begin
      wcl_code = mrt_pkg::WCL_5CK;
    end else begin
      wcl_code = mrt_pkg::WCL_6CK;
    end
  end

  // Array access is outside this block, so reads and writes only make sense in readback mode.
  assign refuse = (op_in == mrt_pkg::OP_MODE) ? (mode_in[mrt_pkg::RBS_BIT] && !readback && !banks_idle_in)  // [R17]
                                              : !readback;  // [R20]

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state                 <= mrt_pkg::ST_IDLE;
      readback              <= 1'b0;
      busy_out              <= 1'b0;
      done_out              <= 1'b0;
      refused_out           <= 1'b0;
      got                   <= '0;
      link.cs_n             <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= mrt_pkg::CMD_NOP;
      link.bank_group_lines <= 2'h0;
      link.bank_lines       <= 2'h0;
      link.address_lines    <= 18'h00000;
      link.wdata            <= 8'h00;
      link.sync             <= 1'b0;
      link.dev_pick_n       <= 1'b1;
    end else begin
      done_out    <= 1'b0;
      refused_out <= 1'b0;
      link.cs_n   <= 1'b1;
      link.sync   <= 1'b0;
      {link.ras_n, link.cas_n, link.we_n} <= mrt_pkg::CMD_NOP;
      unique case (state)
        mrt_pkg::ST_IDLE: begin
          if (req_in && refuse) begin
            refused_out <= 1'b1;
          end else if (req_in) begin
            link.cs_n       <= 1'b0;
            link.dev_pick_n <= pick_n_in;
            unique case (op_in)
              mrt_pkg::OP_MODE: begin
                {link.ras_n, link.cas_n, link.we_n} <= mrt_pkg::CMD_MRS;  // [R1]
                {link.bank_group_lines, link.bank_lines} <= {1'b0, mrt_pkg::SEL_THIS};  // [R2] [R3]
                link.address_lines <= {5'h00, mode_in[12:11], wcl_code, mode_in[8:0]};  // [R3] [R7]
                readback <= mode_in[mrt_pkg::RBS_BIT];  // [R15]
                if (mode_in[mrt_pkg::GEAR_BIT]) begin
                  busy_out <= 1'b1;
                  state    <= mrt_pkg::ST_SYNC;  // [R13]
                end else begin
                  done_out <= 1'b1;  // [R14]
                end
              end
              mrt_pkg::OP_READ: begin
                {link.ras_n, link.cas_n, link.we_n} <= mrt_pkg::CMD_RD;  // [R18]
                link.address_lines <= {7'h00, auto_pre_in, 8'h00, loc_in};
                busy_out <= 1'b1;
                got      <= '0;
                state    <= mrt_pkg::ST_READ;
              end
              default: begin
                {link.ras_n, link.cas_n, link.we_n} <= mrt_pkg::CMD_WR;  // [R22]
                link.address_lines <= {7'h00, auto_pre_in, 8'h00, loc_in};
                link.wdata <= wdata_in;
                done_out   <= 1'b1;
              end
            endcase
          end
        end
        mrt_pkg::ST_SYNC: begin
          link.sync <= 1'b1;  // [R13]
          busy_out  <= 1'b0;
          done_out  <= 1'b1;
          state     <= mrt_pkg::ST_IDLE;
        end
        default: begin
          if (link.rvalid) begin
            got <= got + 1'b1;
            if (got == BW'(BURST - 1)) begin
              busy_out <= 1'b0;
              done_out <= 1'b1;  // [R19]
              state    <= mrt_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out  <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rdata_out  <= link.rdata;
      rvalid_out <= link.rvalid;
    end
  end
endmodule

// ### test/mrt_chk.sv
// Assertions on the link that joins the controller end to the device end.
// Assumes one clk_in for both ends and that every mode-set reaches the device.
`timescale 1ns/10ps
module mrt_chk (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bank_group_lines,
  input wire logic [1:0]  bank_lines,
  input wire logic [17:0] address_lines,
  input wire logic        sync,
  input wire logic        rvalid
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic ms;
  logic rd;
  logic rb;
  assign ms = !cs_n && {ras_n, cas_n, we_n} == 3'h0;
  assign rd = !cs_n && {ras_n, cas_n, we_n} == 3'h5;
  // Per-device masking is not modelled, so the tracked mode can run ahead of a masked device.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) rb <= 1'b0;
    else if (ms) rb <= address_lines[2];
  end
  cmd_lines_a: assert property (!cs_n && !ras_n |-> !cas_n && !we_n)
    else $error("row strobe low without column and write strobes");
  select_three_a: assert property (ms |-> {bank_group_lines[0], bank_lines} == 3'h3)
    else $error("mode-set select field wrong");
  reserved_zero_a: assert property (ms |-> !bank_group_lines[1] && !address_lines[17] && !address_lines[13])
    else $error("reserved bit set in mode-set");
  latency_code_a: assert property (ms |-> address_lines[10:9] != 2'h3)
    else $error("reserved latency code sent");
  burst_len_a: assert property ($rose(rvalid) |-> rvalid [*8] ##1 !rvalid)
    else $error("readback burst not eight beats");
  read_answer_a: assert property (rd && rb |-> ##2 $rose(rvalid))
    else $error("readback read not answered");
  stray_beat_a: assert property ($rose(rvalid) |-> $past(rd, 2))
    else $error("beats without read");
  sync_cause_a: assert property (sync |-> $past(ms && address_lines[3]))
    else $error("sync pulse without quarter rate mode-set");
  sync_pulse_a: assert property (sync |=> !sync)
    else $error("sync pulse longer than one cycle");
  rb_cmds_a: assert property (!cs_n && rb |-> {ras_n, cas_n, we_n} inside {3'h0, 3'h4, 3'h5})
    else $error("illegal command in readback mode");
  cover property (ms);
  cover property ($rose(rvalid));
  cover property (sync);
endmodule

// ### test/ddr_mode_register_three_bench.sv
// Bench joining controller and device, with a reference model of the register fields and readback.
// Assumes a 25 MHz clock and a shortened temperature refresh period.
`timescale 1ns/10ps
module ddr_mode_register_three_bench;
  localparam int TCYC = 16;
  logic             clk_in = 1'b0;
  logic             sys_rst_in = 1'b1;
  logic             req = 1'b0;
  mrt_pkg::mrt_op_t op = mrt_pkg::OP_MODE;
  logic [12:0]      mode = 13'h0000;
  logic [12:0]      m;
  logic [11:0]      rate = 12'h640;
  logic [1:0]       loc = 2'h0;
  logic             apre = 1'b0;
  logic [7:0]       wd = 8'h00;
  logic             idle = 1'b1;
  logic             pick_n = 1'b0;
  logic [1:0]       temp = 2'h0;
  logic             crc = 1'b0;
  logic             msk = 1'b0;
  logic             perr = 1'b0;
  logic             done, refd, rvo, got_ok, tr_o, pd_o, qr_o, ga_o, rb_o, re_o, ce_o, gp_o, gp_q, bsy;
  logic [7:0]       rdo;
  logic [1:0]       fmt_o, tst_o, pg_o;
  logic [2:0]       wcl_o, ref_o;
  logic [3:0]       fl_o;
  logic [15:0]      lf = 16'hc284;
  logic [7:0]       q[$];
  int               num_errors = 0;
  int               cmp_count = 0;
  mrt_link_if link ();
  mrt_ctrl i_mrt_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link.ctrl), .req_in(req), .op_in(op),
    .mode_in(mode), .rate_in(rate), .loc_in(loc), .auto_pre_in(apre), .wdata_in(wd), .banks_idle_in(idle),
    .pick_n_in(pick_n), .busy_out(bsy), .done_out(done), .refused_out(refd), .rdata_out(rdo), .rvalid_out(rvo));
  mrt_device #(.TEMP_CYC(TCYC)) i_mrt_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link.dev),
    .temp_in(temp), .crc_en_in(crc), .mask_en_in(msk), .parity_err_in(perr), .read_format_out(fmt_o),
    .crc_mask_write_latency_out(wcl_o), .write_frame_len_out(fl_o), .refresh_mode_out(ref_o),
    .temp_report_out(tr_o), .temp_status_out(tst_o), .per_device_out(pd_o), .quarter_rate_out(qr_o),
    .gear_aligned_out(ga_o), .gear_phase_out(gp_o), .readback_mode_out(rb_o), .page_out(pg_o),
    .reserved_err_out(re_o), .cmd_err_out(ce_o));
  mrt_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .bank_group_lines(link.bank_group_lines), .bank_lines(link.bank_lines),
    .address_lines(link.address_lines), .sync(link.sync), .rvalid(link.rvalid));
  initial forever #20 clk_in = ~clk_in;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] beat(input logic [7:0] b, input logic [1:0] f, input int i);
    if (f == 2'h0) return {8{b[7 - i]}};
    if (f == 2'h2) return (b << i) | (b >> (8 - i));
    return b;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Beats are gathered at the falling edge so that no sample races the design's own updates.
  task automatic run(input mrt_pkg::mrt_op_t o, input logic [12:0] v, input logic [1:0] l);
    int i;
    q.delete();
    @(posedge clk_in);
    req <= 1'b1;
    op <= o;
    mode <= v;
    loc <= l;
    @(posedge clk_in);
    req <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_in);
      if (rvo === 1'b1) q.push_back(rdo);
      if (done === 1'b1 || refd === 1'b1) break;
    end
    if (i == 40) begin
      num_errors++;
      give_verdict();
    end
    got_ok = done;
    chk(bsy, 1'b0);
    repeat (3) @(negedge clk_in);
  endtask
  task automatic expect_mode(input logic [12:0] v);
    int c;
    c = rate <= 1600 ? 0 : rate <= 2666 ? 1 : 2;
    chk(fmt_o, v[12:11]);
    chk(wcl_o, crc && msk ? 4 + c : 0);
    chk(fl_o, crc ? 10 : 8);
    chk(ref_o, v[8:6]);
    chk(tr_o, v[5]);
    chk(pd_o, v[4]);
    chk(qr_o, v[3]);
    chk(rb_o, v[2]);
    chk(pg_o, v[1:0]);
    chk(re_o, v[12:11] == 2'h3 || v[8:6] inside {3'h3, 3'h4, 3'h7});
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      repeat (13) lf = lfsr(lf);
      m = lf[12:0] & 13'h1fe3;
      @(posedge clk_in);
      rate <= 12'd1200 + 12'(lf[10:0]);
      crc <= lf[13];
      msk <= lf[14];
      temp <= lf[15:14];
      run(mrt_pkg::OP_MODE, m, 2'h0);
      expect_mode(m);
    end
    run(mrt_pkg::OP_MODE, 13'h0011, 2'h0);
    @(posedge clk_in) pick_n <= 1'b1;
    run(mrt_pkg::OP_MODE, 13'h0002, 2'h0);
    chk(pg_o, 2'h1);
    @(posedge clk_in) pick_n <= 1'b0;
    @(posedge clk_in) idle <= 1'b0;
    run(mrt_pkg::OP_MODE, 13'h0006, 2'h0);
    chk(got_ok, 1'b0);
    chk(rb_o, 1'b0);
    @(posedge clk_in) idle <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      m = 13'h0026 | (13'(f) << 11);
      run(mrt_pkg::OP_MODE, m, 2'h0);
      run(mrt_pkg::OP_READ, 13'h0000, 2'h2);
      chk(q.size(), 8);
      foreach (q[i]) chk(q[i], beat(m[7:0], f[1:0], i));
    end
    chk(tst_o, temp);
    @(posedge clk_in) temp <= ~temp;
    // Three synchroniser stages, one agreement cycle and up to a full tick period.
    repeat (TCYC + 6) @(negedge clk_in);
    chk(tst_o, temp);
    run(mrt_pkg::OP_MODE, 13'h0804, 2'h0);
    @(posedge clk_in);
    wd <= lf[7:0];
    apre <= lf[8];
    run(mrt_pkg::OP_WRITE, 13'h0000, 2'h1);
    run(mrt_pkg::OP_READ, 13'h0000, 2'h1);
    chk(q[0], wd);
    run(mrt_pkg::OP_MODE, 13'h0805, 2'h0);
    @(posedge clk_in) perr <= 1'b1;
    @(posedge clk_in) perr <= 1'b0;
    run(mrt_pkg::OP_READ, 13'h0000, 2'h0);
    chk(q[7], 8'h05);
    chk(ce_o, 1'b0);
    run(mrt_pkg::OP_MODE, 13'h000c, 2'h0);
    chk(qr_o, 1'b1);
    chk(ga_o, 1'b1);
    gp_q = gp_o;
    @(negedge clk_in);
    chk(gp_o, !gp_q);
    @(posedge clk_in) sys_rst_in <= 1'b1;
    repeat (2) @(negedge clk_in);
    chk(rb_o, 1'b0);
    chk(qr_o, 1'b0);
    @(posedge clk_in) sys_rst_in <= 1'b0;
    run(mrt_pkg::OP_READ, 13'h0000, 2'h2);
    chk(got_ok, 1'b0);
    give_verdict();
  end
endmodule
